// ### design/ecnt_defines.vh
// Constants for the event up/down counter block
`ifndef ECNT_DEFINES_VH
`define ECNT_DEFINES_VH

// Variant codes
`define ECNT_MODE_UP       2'h0
`define ECNT_MODE_DOWN     2'h1
`define ECNT_MODE_BOTH     2'h2

// Register byte offsets
`define ECNT_OFF_CTRL      12'h000
`define ECNT_OFF_UPPER     12'h004
`define ECNT_OFF_START     12'h008
`define ECNT_OFF_COUNT     12'h00c
`define ECNT_OFF_STAT      12'h010

// Control field positions
`define ECNT_CTRL_UP_AUTO  0
`define ECNT_CTRL_ZR_AUTO  1
`define ECNT_CTRL_CLR_LONG 2
`define ECNT_CTRL_LD_LONG  3

// Reset values
`define ECNT_RST_CTRL      4'h0
`define ECNT_RST_UPPER     16'hffff
`define ECNT_RST_START     16'h0001

// Timing: pulse limits in ms and clock rate in kHz
`define ECNT_T_MIN_SHORT_MS 32'h64
`define ECNT_T_MIN_LONG_MS  32'h15e
`define ECNT_T_MAX_MS       32'h7530
`define ECNT_CLK_KHZ        32'h186a0

`endif

// ### design/ecnt_counter.v
// Event up/down counter with pulse-checked clear and load, APB slave
`timescale 1ns/1ps
`include "ecnt_defines.vh"

// Pulse width checker: flags a low-high-low pulse inside a window
module ecnt_pulse
#(
    parameter [31:0] MIN_SHORT = 32'h1,
    parameter [31:0] MIN_LONG  = 32'h1,
    parameter [31:0] MAX_CYC   = 32'h1
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        sig,
    input  wire        long_sel,
    output reg         valid
);
    reg        sig_q;
    reg [31:0] width_q;
    wire [31:0] min_cyc;
    wire        fall;
    wire        long_enough;
    wire        short_enough;

    assign min_cyc = long_sel ? MIN_LONG : MIN_SHORT;
    assign fall    = sig_q & ~sig;

    // Width window, both ends inclusive
    assign long_enough  = (width_q >= min_cyc);
    assign short_enough = (width_q <= MAX_CYC);

    // High-time counter, saturating
    always @(posedge clk)
    begin
        if (rst)
        begin
            sig_q   <= 1'b0;
            width_q <= 32'h0;
            valid   <= 1'b0;
        end
        else
        begin
            sig_q <= sig;
            if (sig && !sig_q)
                width_q <= 32'h1;
            else if (sig && width_q != 32'hffffffff)
                width_q <= width_q + 32'h1;
            // Accept only widths inside the window
            valid <= fall && long_enough && short_enough;
        end
    end
endmodule

// Rising edge detector, disabled for a variant that ignores the input
module ecnt_edge
#(
    parameter ENABLE = 1
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        sig,
    output wire        rise
);
    reg        sig_q;

    // Idle level after reset is low, so an input already high after reset gives an edge
    always @(posedge clk)
    begin
        if (rst)
            sig_q <= 1'b0;
        else
            sig_q <= sig;
    end

    assign rise = (ENABLE != 0) && sig && !sig_q;
endmodule

// Sixteen-bit register with byte-lane writes
module ecnt_reg16
#(
    parameter [15:0] RST_VAL = 16'h0
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        we,
    input  wire [1:0]  strb,
    input  wire [15:0] wdata,
    output reg  [15:0] q
);
    // Each byte lane written only when its strobe is set
    always @(posedge clk)
    begin
        if (rst)
            q <= RST_VAL;
        else if (we)
        begin
            if (strb[0])
                q[7:0] <= wdata[7:0];
            if (strb[1])
                q[15:8] <= wdata[15:8];
        end
    end
endmodule

// Counter core with register file
module ecnt_counter
#(
    parameter [1:0]  MODE      = `ECNT_MODE_BOTH,
    parameter        CNT_W     = 16,
    parameter [31:0] MIN_SHORT = `ECNT_T_MIN_SHORT_MS * `ECNT_CLK_KHZ,
    parameter [31:0] MIN_LONG  = `ECNT_T_MIN_LONG_MS * `ECNT_CLK_KHZ,
    parameter [31:0] MAX_CYC   = `ECNT_T_MAX_MS * `ECNT_CLK_KHZ
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        up_in,
    input  wire        down_in,
    input  wire        clr_in,
    input  wire        load_in,
    output reg         upper_out,
    output reg         lower_out
);
    reg  [3:0]       ctrl_q;
    wire [CNT_W-1:0] upper_q;
    wire [CNT_W-1:0] start_q;
    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] cnt_d;
    reg              upper_d;
    reg              lower_d;
    reg              hit;
    wire             up_edge;
    wire             down_edge;
    wire             clr_ok;
    wire             ld_ok;
    wire             wr;
    wire             mapped;
    wire             up_auto;
    wire             zr_auto;

    // Register selects
    wire             sel_ctrl;
    wire             sel_upper;
    wire             sel_start;
    wire             sel_count;
    wire             sel_stat;

    // Read path
    reg  [31:0]      rdata_d;

    assign up_auto = ctrl_q[`ECNT_CTRL_UP_AUTO];
    assign zr_auto = ctrl_q[`ECNT_CTRL_ZR_AUTO];

    // Edge detection per variant
    ecnt_edge
    #(
        .ENABLE (MODE != `ECNT_MODE_DOWN)
    )
    u_up
    (
        .clk  (clk),
        .rst  (rst),
        .sig  (up_in),
        .rise (up_edge)
    );

    ecnt_edge
    #(
        .ENABLE (MODE != `ECNT_MODE_UP)
    )
    u_down
    (
        .clk  (clk),
        .rst  (rst),
        .sig  (down_in),
        .rise (down_edge)
    );

    // Clear pulse checker
    ecnt_pulse
    #(
        .MIN_SHORT (MIN_SHORT),
        .MIN_LONG  (MIN_LONG),
        .MAX_CYC   (MAX_CYC)
    )
    u_clr
    (
        .clk      (clk),
        .rst      (rst),
        .sig      (clr_in),
        .long_sel (ctrl_q[`ECNT_CTRL_CLR_LONG]),
        .valid    (clr_ok)
    );

    // Load pulse checker
    ecnt_pulse
    #(
        .MIN_SHORT (MIN_SHORT),
        .MIN_LONG  (MIN_LONG),
        .MAX_CYC   (MAX_CYC)
    )
    u_ld
    (
        .clk      (clk),
        .rst      (rst),
        .sig      (load_in),
        .long_sel (ctrl_q[`ECNT_CTRL_LD_LONG]),
        .valid    (ld_ok)
    );

    // Next count and threshold outputs
    always @*
    begin
        cnt_d   = cnt_q;
        hit     = 1'b0;
        if (clr_ok)
        begin
            cnt_d = {CNT_W{1'b0}};
            hit   = 1'b1;
        end
        else if (ld_ok)
        begin
            cnt_d = start_q;
            hit   = 1'b1;
        end
        else if (up_auto && cnt_q == upper_q)
            cnt_d = {CNT_W{1'b0}};
        else if (zr_auto && cnt_q == {CNT_W{1'b0}})
            cnt_d = start_q;
        else if (up_edge && down_edge)
            hit = 1'b1;
        else if (up_edge && cnt_q != upper_q)
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        else if (down_edge && cnt_q != {CNT_W{1'b0}})
            cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        upper_d = !hit && (cnt_d == upper_q);
        lower_d = !hit && (cnt_d == {CNT_W{1'b0}});
    end

    // Counter state
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q     <= {CNT_W{1'b0}};
            upper_out <= 1'b0;
            lower_out <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            upper_out <= upper_d;
            lower_out <= lower_d;
        end
    end

    // Offset decode
    assign sel_ctrl  = (paddr == `ECNT_OFF_CTRL);
    assign sel_upper = (paddr == `ECNT_OFF_UPPER);
    assign sel_start = (paddr == `ECNT_OFF_START);
    assign sel_count = (paddr == `ECNT_OFF_COUNT);
    assign sel_stat  = (paddr == `ECNT_OFF_STAT);
    assign mapped    = sel_ctrl || sel_upper || sel_start || sel_count
                       || sel_stat;

    // APB handshake, zero wait states
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr      = psel && penable && pwrite;

    // Control register, lane 0 only
    always @(posedge clk)
    begin
        if (rst)
            ctrl_q <= `ECNT_RST_CTRL;
        else if (wr && sel_ctrl && pstrb[0])
            ctrl_q <= pwdata[3:0];
    end

    // Upper threshold register
    ecnt_reg16
    #(
        .RST_VAL (`ECNT_RST_UPPER)
    )
    u_upper
    (
        .clk   (clk),
        .rst   (rst),
        .we    (wr && sel_upper),
        .strb  (pstrb[1:0]),
        .wdata (pwdata[15:0]),
        .q     (upper_q)
    );

    // Start value register
    ecnt_reg16
    #(
        .RST_VAL (`ECNT_RST_START)
    )
    u_start
    (
        .clk   (clk),
        .rst   (rst),
        .we    (wr && sel_start),
        .strb  (pstrb[1:0]),
        .wdata (pwdata[15:0]),
        .q     (start_q)
    );

    // Read multiplexer
    always @*
    begin
        case (paddr)
            `ECNT_OFF_CTRL:  rdata_d = {28'h0, ctrl_q};
            `ECNT_OFF_UPPER: rdata_d = {16'h0, upper_q};
            `ECNT_OFF_START: rdata_d = {16'h0, start_q};
            `ECNT_OFF_COUNT: rdata_d = {16'h0, cnt_q};
            `ECNT_OFF_STAT:  rdata_d = {30'h0, lower_out, upper_out};
            default:         rdata_d = 32'h0;
        endcase
    end

    // Read data, registered at the setup cycle
    always @(posedge clk)
    begin
        if (rst)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= rdata_d;
    end
endmodule

// ### tb/ecnt_src.sv
// Far-side logic model: emits high pulses of a set width
`timescale 1ns/1ps
module ecnt_src
(
    input  wire        clk,
    input  wire        go,
    input  wire [31:0] width,
    output reg         sig = 1'b0
);
    reg [31:0] n_q = 32'h0;
    // Hold the line high for width samples, then release low
    always @(posedge clk)
    begin
        if (go)
        begin
            sig <= 1'b1;
            n_q <= width;
        end
        else if (n_q > 32'h1)
            n_q <= n_q - 32'h1;
        else
        begin
            sig <= 1'b0;
            n_q <= 32'h0;
        end
    end
endmodule

// ### tb/ecnt_checker.sv
// Port assertions for the event counter
`timescale 1ns/1ps
module ecnt_checker
#(
    parameter [31:0] MIN_SHORT = 32'h1,
    parameter [31:0] MIN_LONG  = 32'h1,
    parameter [31:0] MAX_CYC   = 32'h1
)
(
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        up_in,
    input wire        down_in,
    input wire        clr_in,
    input wire        load_in,
    input wire        upper_out,
    input wire        lower_out
);
    reg  [3:0]  ctl_q, hist_q;
    reg  [31:0] wc_q, wl_q;
    wire        quiet = !(clr_in | load_in) && hist_q == 4'h0;
    wire [31:0] mc = ctl_q[2] ? MIN_LONG : MIN_SHORT;
    wire [31:0] ml = ctl_q[3] ? MIN_LONG : MIN_SHORT;
    // Shadow control, pulse widths, recent pulse activity
    always @(posedge clk)
    begin
        hist_q <= {hist_q[2:0], clr_in | load_in};
        wc_q <= clr_in ? wc_q + 32'h1 : 32'h0;
        wl_q <= load_in ? wl_q + 32'h1 : 32'h0;
        if (rst)
            ctl_q <= 4'h0;
        else if (psel && penable && pwrite && paddr == 12'h000)
            ctl_q <= pwdata[3:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_zeroed;
        !upper_out && !lower_out ##1 lower_out;
    endsequence
    a_both_edges: assert property ($rose(up_in) && $rose(down_in)
        && quiet && ctl_q[1:0] == 2'h0 |=> !upper_out && !lower_out)
        else $error("both edges moved outputs");
    a_upper_hold: assert property (upper_out && !ctl_q[0] && quiet
        && !$rose(down_in) |=> upper_out) else $error("upper hold lost");
    a_upper_release: assert property (upper_out && !ctl_q[0]
        && quiet && $rose(down_in) && !$rose(up_in) |=> !upper_out)
        else $error("down edge kept upper");
    a_upper_auto: assert property (upper_out && ctl_q[0] && quiet
        |=> !upper_out) else $error("upper pulse too long");
    a_zero_hold: assert property (lower_out && !ctl_q[1] && quiet
        && !$rose(up_in) |=> lower_out) else $error("zero hold lost");
    a_zero_auto: assert property (lower_out && ctl_q[1] && quiet
        |=> !lower_out) else $error("zero pulse too long");
    a_clear_zero: assert property ($fell(clr_in) && wc_q >= mc
        && wc_q <= MAX_CYC && !ctl_q[1] |-> ##[1:3] s_zeroed)
        else $error("clear missed");
    a_load_low: assert property ($fell(load_in) && wl_q >= ml
        && wl_q <= MAX_CYC && wc_q == 0
        |-> ##[1:3] (!upper_out && !lower_out))
        else $error("load kept outputs");
endmodule

bind ecnt_counter ecnt_checker #(.MIN_SHORT(MIN_SHORT), .MIN_LONG(MIN_LONG),
    .MAX_CYC(MAX_CYC)) u_chk (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .up_in(up_in), .down_in(down_in), .clr_in(clr_in), .load_in(load_in),
    .upper_out(upper_out), .lower_out(lower_out));

// ### tb/tb_event_up_down_counter.sv
// Self-checking bench for the event counter
`timescale 1ns/1ps
module tb_event_up_down_counter;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, upper_out, lower_out, serr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, wv = 0, s = 20;
    logic [3:0]  go = 0;
    wire  [3:0]  sig;
    int          n_errors = 0, compares = 0, c = 0;
    int          tm[9] = '{4, 4, 4, 4, 4, 8, 8, 8, 12};
    int          tc[9] = '{0, 0, 0, 0, 4, 0, 8, 8, 0};
    int          tw[9] = '{3, 4, 20, 21, 7, 4, 7, 8, 5};
    // Clock, far-side pulse sources, design
    initial forever #5 clk = ~clk;
    ecnt_src u_src[3:0] (.clk(clk), .go(go), .width(wv), .sig(sig));
    ecnt_counter #(.MIN_SHORT(32'h4), .MIN_LONG(32'h8), .MAX_CYC(32'h14))
    i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .up_in(sig[0]), .down_in(sig[1]), .clr_in(sig[2]),
        .load_in(sig[3]), .upper_out(upper_out), .lower_out(lower_out));
    function logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function logic ok(input logic [31:0] w, input logic lng);
        return w >= (lng ? 32'h8 : 32'h4) && w <= 32'h14;
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask
    task results();
        $display("mismatches %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer, request held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        serr = pslverr;
        psel <= 0;
        penable <= 0;
        if (k == 20)
        begin
            n_errors++;
            results();
        end
    endtask
    task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(n, e, rd);
    endtask
    task pulse(input logic [3:0] m, input logic [31:0] w);
        @(posedge clk);
        go <= m;
        wv <= w;
        @(posedge clk);
        go <= 0;
        repeat (w + 5) @(posedge clk);
    endtask
    // Main sequence
    initial
    begin
        logic [3:0] m;
        int i;
        repeat (5) @(posedge clk);
        rst <= 0;
        rchk("ctrl", 12'h000, 32'h0);
        rchk("upper", 12'h004, 32'hffff);
        rchk("start", 12'h008, 32'h1);
        rchk("stat", 12'h010, 32'h2);
        apb(0, 12'h014, 0);
        chk("slverr", 1, serr);
        apb(1, 12'h004, 5);
        apb(1, 12'h008, 3);
        repeat (6) pulse(1, 1);
        c = 5;
        rchk("count", 12'h00c, 5);
        for (i = 0; i < 24; i++)
        begin
            m = 4'(xs() % 3) + 4'h1;
            if (m == 1 && c != 5) c++;
            if (m == 2 && c != 0) c--;
            pulse(m, 1);
            rchk("count", 12'h00c, c);
            rchk("stat", 12'h010, {c == 0, c == 5});
        end
        for (i = 0; i < 9; i++)
        begin
            apb(1, 12'h000, tc[i]);
            pulse(1, 1);
            pulse(1, 1);
            c = (c + 2 > 5) ? 5 : c + 2;
            pulse(tm[i], tw[i]);
            c = (tm[i][2] && ok(tw[i], tc[i][2])) ? 0 :
                (tm[i][3] && ok(tw[i], tc[i][3])) ? 3 : c;
            rchk("pulse", 12'h00c, c);
        end
        pulse(1, 1);
        apb(1, 12'h000, 3);
        pulse(2, 1);
        rchk("auto zero", 12'h00c, 3);
        pulse(1, 1);
        pulse(1, 1);
        rchk("auto wrap", 12'h00c, 3);
        results();
    end
endmodule
